/* verilog/sac_pkg.sv */
// Package with register map, field layouts, reset values and timing for the converter control block.
package sac_pkg;
  localparam logic [7:0] SAC_OFS_CTRL = 8'h3C;
  localparam logic [7:0] SAC_OFS_RESH = 8'h3D;
  localparam logic [7:0] SAC_OFS_RESL = 8'h3E;
  localparam logic [7:0] SAC_OFS_CLKC = 8'h3F;
  // Control/status bit positions.
  localparam int SAC_BIT_DONE = 7;
  localparam int SAC_BIT_IEN = 6;
  localparam int SAC_BIT_CONT = 5;
  // Clock control bit positions.
  localparam int SAC_BIT_DIV_LO = 5;
  localparam int SAC_BIT_SRC = 4;
  localparam int SAC_BIT_JUST_LO = 2;
  localparam logic [4:0] SAC_CH_RESET = 5'h1F;
  localparam logic [4:0] SAC_CH_OFF = 5'h1F;
  localparam logic [4:0] SAC_CH_LAST_EXT = 5'h05;
  localparam logic [4:0] SAC_CH_BANDGAP = 5'h06;
  localparam logic [4:0] SAC_CH_REF_HIGH = 5'h1D;
  localparam logic [4:0] SAC_CH_REF_LOW = 5'h1E;
  localparam logic [7:0] SAC_CLKC_RESET = 8'h04;
  localparam logic [7:0] SAC_RES_RESET = 8'h00;
  // Converter clock cycles per conversion, counted from the start write.
  localparam logic [4:0] SAC_CONV_CYCLES = 5'h10;
  typedef enum logic [1:0] {
    SAC_JUST_TRUNC = 2'b00,
    SAC_JUST_RIGHT = 2'b01,
    SAC_JUST_LEFT = 2'b10,
    SAC_JUST_SIGNED = 2'b11
  } sac_just_t;
  typedef enum logic [1:0] {
    SAC_ST_IDLE = 2'b00,
    SAC_ST_CONV = 2'b01,
    SAC_ST_OFF = 2'b10
  } sac_state_t;
endpackage

/* verilog/sac_prescaler.sv */
// Converter clock enable generator: selectable source and divide by 1, 2, 4, 8 or 16.
`timescale 1ns/1ps
module sac_prescaler
  import sac_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Control
  input wire logic restart,
  input wire logic src_bus,
  input wire logic crystal_tick,
  input wire logic [2:0] clock_prescale,
  // Output
  output logic conv_tick
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;
  logic src_tick;
  logic [3:0] limit;

  always_comb begin
    src_tick = src_bus ? 1'b1 : crystal_tick;
    case (clock_prescale)
      3'h0: limit = 4'h0;
      3'h1: limit = 4'h1;
      3'h2: limit = 4'h3;
      3'h3: limit = 4'h7;
      default: limit = 4'hF;
    endcase
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (restart) begin
      cnt_nxt = 4'h0;
    end else if (src_tick) begin
      if (cnt_r >= limit) begin
        cnt_nxt = 4'h0;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 4'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 4'h0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign conv_tick = tick_r;
endmodule

/* verilog/sac_ctrl.sv */
// Control, status and result registers of the 10-bit successive-approximation converter.
`timescale 1ns/1ps
module sac_ctrl
  import sac_pkg::*;
#(
  parameter int RES_W = 10
)(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Crystal clock enable and analog side
  input wire logic crystal_tick,
  input wire logic [RES_W-1:0] analog_result,
  output logic [4:0] channel_select,
  output logic converter_power_on,
  output logic sample_strobe,
  output logic first_after_off,
  // Interrupt request to the processor
  output logic irq
);
  logic [7:0] clkc_r, clkc_nxt;
  logic ien_r, ien_nxt;
  logic cont_r, cont_nxt;
  logic [4:0] ch_r, ch_nxt;
  logic done_r, done_nxt;
  logic irq_r, irq_nxt;
  logic [7:0] resh_r, resh_nxt;
  logic [7:0] resl_r, resl_nxt;
  logic lock_r, lock_nxt;
  logic stab_r, stab_nxt;
  logic [4:0] cyc_r, cyc_nxt;
  sac_state_t st_r, st_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic smp_r, smp_nxt;
  logic conv_tick;
  logic wr_ctrl, wr_clkc, rd_resl, rd_resh;
  logic finish;
  logic [7:0] new_h, new_l;
  sac_just_t just;
  logic pwr_r, pwr_nxt;
  // Converter ticks seen since the last start, kept apart from the state counter.
  // The length checks use it so that they are not read back from the counter they guard.
  logic [4:0] seen_r, seen_nxt;

  assign wr_ctrl = wr && addr == SAC_OFS_CTRL;
  assign wr_clkc = wr && addr == SAC_OFS_CLKC;
  assign rd_resl = rd && addr == SAC_OFS_RESL;
  assign rd_resh = rd && addr == SAC_OFS_RESH;
  assign just = sac_just_t'(clkc_r[SAC_BIT_JUST_LO+1:SAC_BIT_JUST_LO]);

  sac_prescaler u_presc (
    .clock(clock),
    .rstn(rstn),
    .restart(wr_ctrl),
    .src_bus(clkc_r[SAC_BIT_SRC]),
    .crystal_tick(crystal_tick),
    .clock_prescale(clkc_r[SAC_BIT_DIV_LO+2:SAC_BIT_DIV_LO]),
    .conv_tick(conv_tick)
  );

  // Layout of a fresh result in the selected justification mode.
  function automatic logic [15:0] sac_layout(input sac_just_t m, input logic [9:0] v);
    logic [15:0] r;
    r = 16'h0000;
    case (m)
      SAC_JUST_TRUNC: r = {8'h00, v[9:2]};
      SAC_JUST_RIGHT: r = {6'h00, v[9:8], v[7:0]};
      SAC_JUST_LEFT: r = {v[9:2], v[1:0], 6'h00};
      SAC_JUST_SIGNED: r = {~v[9], v[8:2], v[1:0], 6'h00};
      default: r = 16'h0000;
    endcase
    return r;
  endfunction

  // The conversion ends on the 16th converter tick after the start write; the write restarts
  // the prescaler, so no partial tick comes before the first boundary.
  assign finish = st_r == SAC_ST_CONV && conv_tick && cyc_r == SAC_CONV_CYCLES - 5'h01;
  assign {new_h, new_l} = sac_layout(just, analog_result[9:0]);

  always_comb begin
    clkc_nxt = clkc_r;
    ien_nxt = ien_r;
    cont_nxt = cont_r;
    ch_nxt = ch_r;
    done_nxt = done_r;
    irq_nxt = irq_r;
    resh_nxt = resh_r;
    resl_nxt = resl_r;
    lock_nxt = lock_r;
    stab_nxt = stab_r;
    cyc_nxt = cyc_r;
    st_nxt = st_r;
    smp_nxt = 1'b0;
    seen_nxt = seen_r;
    if (wr_clkc) begin
      clkc_nxt = {wdata[7:2], 2'b00};
    end
    // Clears first, so that a completion in the same cycle wins.
    if (wr_ctrl || wr_clkc || rd_resl) begin
      done_nxt = 1'b0;
    end
    if (wr_ctrl || rd_resl || rd_resh) begin
      irq_nxt = 1'b0;
    end
    // The lock freezes both bytes; software that reads only the high byte loses every
    // later result, which is the documented cost of the interlock.
    if (rd_resh && just != SAC_JUST_TRUNC) begin
      lock_nxt = 1'b1;
    end
    if (rd_resl) begin
      lock_nxt = 1'b0;
    end
    if (cyc_r != 5'h00 || st_r != SAC_ST_CONV) begin
      cyc_nxt = cyc_r;
    end
    case (st_r)
      SAC_ST_IDLE: st_nxt = SAC_ST_IDLE;
      SAC_ST_CONV: begin
        if (conv_tick) begin
          cyc_nxt = cyc_r + 5'h01;
        end
        if (finish) begin
          smp_nxt = 1'b1;
          cyc_nxt = 5'h00;
          stab_nxt = 1'b0;
          if (!lock_nxt || just == SAC_JUST_TRUNC) begin
            resh_nxt = new_h;
            resl_nxt = new_l;
          end
          if (ien_r) begin
            irq_nxt = 1'b1;
          end else begin
            done_nxt = 1'b1;
          end
          st_nxt = cont_r ? SAC_ST_CONV : SAC_ST_IDLE;
        end
      end
      SAC_ST_OFF: st_nxt = SAC_ST_OFF;
      default: st_nxt = SAC_ST_IDLE;
    endcase
    if (wr_ctrl) begin
      ien_nxt = wdata[SAC_BIT_IEN];
      cont_nxt = wdata[SAC_BIT_CONT];
      // Reserved codes are not refused: they convert whatever the analog side returns.
      ch_nxt = wdata[4:0];
      cyc_nxt = 5'h00;
      if (wdata[4:0] == SAC_CH_OFF) begin
        st_nxt = SAC_ST_OFF;
      end else begin
        if (st_r == SAC_ST_OFF) begin
          stab_nxt = 1'b1;
        end
        st_nxt = SAC_ST_CONV;
      end
    end
    if (wr_ctrl || finish) begin
      seen_nxt = 5'h00;
    end else if (st_r == SAC_ST_CONV && conv_tick) begin
      seen_nxt = seen_r + 5'h01;
    end
    // The power output is registered from the next state so it leaves a flip-flop directly.
    pwr_nxt = st_nxt != SAC_ST_OFF;
    rdata_nxt = 8'h00;
    if (rd) begin
      case (addr)
        SAC_OFS_CTRL: rdata_nxt = {done_r & ~ien_r, ien_r, cont_r, ch_r};
        SAC_OFS_RESH: rdata_nxt = resh_r;
        SAC_OFS_RESL: rdata_nxt = resl_r;
        SAC_OFS_CLKC: rdata_nxt = clkc_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      clkc_r <= SAC_CLKC_RESET;
      ien_r <= 1'b0;
      cont_r <= 1'b0;
      ch_r <= SAC_CH_RESET;
      done_r <= 1'b0;
      irq_r <= 1'b0;
      resh_r <= SAC_RES_RESET;
      resl_r <= SAC_RES_RESET;
      lock_r <= 1'b0;
      stab_r <= 1'b0;
      cyc_r <= 5'h00;
      st_r <= SAC_ST_OFF;
      rdata_r <= 8'h00;
      smp_r <= 1'b0;
      pwr_r <= 1'b0;
      seen_r <= 5'h00;
    end else begin
      clkc_r <= clkc_nxt;
      ien_r <= ien_nxt;
      cont_r <= cont_nxt;
      ch_r <= ch_nxt;
      done_r <= done_nxt;
      irq_r <= irq_nxt;
      resh_r <= resh_nxt;
      resl_r <= resl_nxt;
      lock_r <= lock_nxt;
      stab_r <= stab_nxt;
      cyc_r <= cyc_nxt;
      st_r <= st_nxt;
      rdata_r <= rdata_nxt;
      smp_r <= smp_nxt;
      pwr_r <= pwr_nxt;
      seen_r <= seen_nxt;
    end
  end

  // The channel and power outputs are register copies, so they are flip-flop driven.
  assign rdata = rdata_r;
  assign irq = irq_r;
  assign channel_select = ch_r;
  assign converter_power_on = pwr_r;
  assign sample_strobe = smp_r;
  assign first_after_off = stab_r;

  a_ctrl_write_starts: assert property (@(posedge clock) disable iff (!rstn)
    wr_ctrl && wdata[4:0] != SAC_CH_OFF |=> st_r == SAC_ST_CONV && cyc_r == 5'h00)
    else $error("control write did not start a conversion");
  a_done_sets: assert property (@(posedge clock) disable iff (!rstn)
    finish && !ien_r |=> done_r)
    else $error("done flag not set at completion");
  a_done_clears: assert property (@(posedge clock) disable iff (!rstn)
    (wr_ctrl || wr_clkc || rd_resl) && !finish |=> !done_r)
    else $error("done flag not cleared");
  a_irq_raise: assert property (@(posedge clock) disable iff (!rstn)
    finish && ien_r |=> irq_r && rdata_r[SAC_BIT_DONE] == 1'b0)
    else $error("interrupt not raised at completion");
  a_irq_withdraw: assert property (@(posedge clock) disable iff (!rstn)
    (wr_ctrl || rd_resl || rd_resh) && !finish |=> !irq_r)
    else $error("interrupt not withdrawn");
  a_single_stops: assert property (@(posedge clock) disable iff (!rstn)
    finish && !cont_r && !wr_ctrl |=> st_r == SAC_ST_IDLE)
    else $error("single conversion did not stop");
  a_power_off: assert property (@(posedge clock) disable iff (!rstn)
    wr_ctrl && wdata[4:0] == SAC_CH_OFF |=> !converter_power_on)
    else $error("all-ones channel did not power off");
  a_lock_holds: assert property (@(posedge clock) disable iff (!rstn)
    lock_r && !rd_resl && just != SAC_JUST_TRUNC |=> $stable(resl_r))
    else $error("low byte changed while frozen");
  a_trunc_high: assert property (@(posedge clock) disable iff (!rstn)
    finish && just == SAC_JUST_TRUNC |=> resh_r == 8'h00 && resl_r == $past(analog_result[9:2]))
    else $error("truncated layout wrong");
  a_conv_length: assert property (@(posedge clock) disable iff (!rstn)
    finish |-> seen_r == 5'h0F)
    else $error("conversion length wrong");
  a_conv_ends: assert property (@(posedge clock) disable iff (!rstn)
    st_r == SAC_ST_CONV && conv_tick && seen_r == 5'h0F |-> finish)
    else $error("conversion ran past its last tick");
  // The checks below guard outputs and read-back values that software relies on.
  a_results_ro: assert property (@(posedge clock) disable iff (!rstn)
    wr && (addr == SAC_OFS_RESH || addr == SAC_OFS_RESL) && !finish |=> $stable(resh_r) && $stable(resl_r))
    else $error("result byte changed on a write");
  a_strobe_follows: assert property (@(posedge clock) disable iff (!rstn)
    finish |=> sample_strobe && !first_after_off)
    else $error("completion strobe or stabilisation flag wrong");
  a_power_resume: assert property (@(posedge clock) disable iff (!rstn)
    wr_ctrl && wdata[4:0] != SAC_CH_OFF |=> converter_power_on)
    else $error("converter not powered on a start");
  a_done_masked: assert property (@(posedge clock) disable iff (!rstn)
    rd && addr == SAC_OFS_CTRL && ien_r |=> rdata_r[SAC_BIT_DONE] == 1'b0)
    else $error("done flag visible with interrupt enabled");
endmodule

/* test/sac_ctrl_bench.sv */
// Self-checking bench for the converter control and result register block.
`timescale 1ns/1ps
module sac_ctrl_bench;
  import sac_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic crystal_tick = 1'b0;
  logic [9:0] analog_result = 10'h000;
  logic [7:0] rdata;
  logic [4:0] channel_select;
  logic converter_power_on;
  logic sample_strobe;
  logic first_after_off;
  logic irq;
  logic rd_prev = 1'b0;
  logic [1:0] tick_cnt = 2'h0;
  logic [7:0] exp_q[$];
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;
  int extra;
  logic [1:0] m;
  logic [9:0] v;
  logic [9:0] v2;

  sac_ctrl sac_ctrl_inst (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .crystal_tick(crystal_tick), .analog_result(analog_result),
    .channel_select(channel_select), .converter_power_on(converter_power_on),
    .sample_strobe(sample_strobe), .first_after_off(first_after_off), .irq(irq));

  always #25 clock = ~clock;

  // Crystal ticks come every third clock so the crystal source is visibly slower than the bus.
  always @(posedge clock) begin
    tick_cnt <= (tick_cnt == 2'h2) ? 2'h0 : tick_cnt + 2'h1;
    crystal_tick <= (tick_cnt == 2'h2);
    cycles++;
    if (cycles >= 20000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_range(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      fails++;
      $display("wrong value at %0t: %0d cycles, not in %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // Read data stands only in the cycle after the strobe, so it is sampled exactly there.
  always @(posedge clock) begin
    if (rd_prev && exp_q.size() > 0) chk(rdata, exp_q.pop_front());
    rd_prev <= rd;
  end

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
  endtask

  // A divide of zero waits for the next completion without timing it.
  task automatic wait_done(input int d);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (sample_strobe !== 1'b1 && n < 300);
    if (d > 0) chk_range(n + 1, 16 * d, 17 * d + 4);
  endtask

  task automatic quiet();
    extra = 0;
    repeat (40) begin
      @(posedge clock);
      if (sample_strobe === 1'b1) extra++;
    end
    chk(8'(extra), 8'h00);
  endtask

  function automatic logic [7:0] hi_of(input logic [1:0] md, input logic [9:0] x);
    case (md)
      2'b00: return 8'h00;
      2'b01: return {6'h00, x[9:8]};
      2'b10: return x[9:2];
      default: return {~x[9], x[8:2]};
    endcase
  endfunction

  function automatic logic [7:0] lo_of(input logic [1:0] md, input logic [9:0] x);
    case (md)
      2'b00: return x[9:2];
      2'b01: return x[7:0];
      default: return {x[1:0], 6'h00};
    endcase
  endfunction

  initial begin
    n = int'($urandom(32'h9837));
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    reg_rd(SAC_OFS_CTRL, 8'h1F);
    reg_rd(SAC_OFS_CLKC, SAC_CLKC_RESET);
    reg_wr(SAC_OFS_RESH, 8'hFF);
    reg_wr(SAC_OFS_RESL, 8'hFF);
    reg_rd(SAC_OFS_RESH, 8'h00);
    reg_rd(SAC_OFS_RESL, 8'h00);
    reg_rd(8'h40, 8'h00);
    for (int i = 0; i < 4; i++) begin
      m = 2'(i + 1);
      v = 10'($urandom);
      analog_result <= v;
      if (i > 0) reg_wr(SAC_OFS_CLKC, {4'h1, m, 2'b00});
      reg_wr(SAC_OFS_CTRL, 8'h00);
      wait_done((i == 0) ? 3 : 1);
      reg_rd(SAC_OFS_CTRL, 8'h80);
      reg_rd(SAC_OFS_RESH, hi_of(m, v));
      reg_rd(SAC_OFS_RESL, lo_of(m, v));
      reg_rd(SAC_OFS_CTRL, 8'h00);
    end
    reg_wr(SAC_OFS_CTRL, 8'h20);
    wait_done(1);
    reg_rd(SAC_OFS_RESH, 8'h00);
    v2 = 10'($urandom);
    analog_result <= v2;
    wait_done(0);
    reg_rd(SAC_OFS_RESL, v2[9:2]);
    reg_wr(SAC_OFS_CLKC, 8'h14);
    v = 10'($urandom);
    analog_result <= v;
    reg_wr(SAC_OFS_CTRL, 8'h20);
    wait_done(1);
    reg_rd(SAC_OFS_RESH, {6'h00, v[9:8]});
    v2 = 10'($urandom);
    analog_result <= v2;
    wait_done(0);
    wait_done(0);
    reg_rd(SAC_OFS_RESL, v[7:0]);
    wait_done(0);
    reg_rd(SAC_OFS_RESH, {6'h00, v2[9:8]});
    reg_rd(SAC_OFS_RESL, v2[7:0]);
    reg_wr(SAC_OFS_CTRL, 8'h00);
    repeat (5) @(posedge clock);
    reg_wr(SAC_OFS_CTRL, 8'h00);
    wait_done(1);
    quiet();
    reg_wr(SAC_OFS_CLKC, 8'h14);
    reg_rd(SAC_OFS_CTRL, 8'h00);
    reg_wr(SAC_OFS_CTRL, 8'h43);
    wait_done(1);
    chk({7'h00, irq}, 8'h01);
    reg_rd(SAC_OFS_CTRL, 8'h43);
    reg_rd(SAC_OFS_RESL, v2[7:0]);
    chk({7'h00, irq}, 8'h00);
    reg_wr(SAC_OFS_CTRL, 8'h40);
    wait_done(1);
    reg_wr(SAC_OFS_CTRL, 8'h1F);
    chk({7'h00, irq}, 8'h00);
    chk({7'h00, converter_power_on}, 8'h00);
    quiet();
    reg_wr(SAC_OFS_CTRL, 8'h00);
    chk({6'h00, converter_power_on, first_after_off}, 8'h03);
    for (int c = 0; c < 31; c++) begin
      if (c <= 6 || c >= 29) begin
        reg_wr(SAC_OFS_CTRL, 8'(c));
        chk({3'h0, channel_select}, 8'(c));
      end
    end
    foreach (exp_q[k]) n = k;
    for (int p = 1; p < 6; p++) begin
      if (p != 4) begin
        reg_wr(SAC_OFS_CLKC, {3'(p), 5'h14});
        reg_wr(SAC_OFS_CTRL, 8'h00);
        wait_done((p > 3) ? 16 : (1 << p));
      end
    end
    end_of_test();
  end
endmodule
